// >>> dif_contactor_model.sv
/*
  Motor contactor with its auxiliary contact.
  Assumes mode 0 healthy, 1 contact welded on, 2 contact lost.
*/
`timescale 1ns/1ns
`default_nettype none
module dif_contactor_model #(parameter int DLY = 8) (
  // Contactor coil and fault mode
  input wire logic clk_i,
  input wire logic close_i,
  input wire logic [1:0] mode_i,
  // Auxiliary contact
  output logic aux_o
);
  int cnt_q;
  // Closing takes DLY cycles; opening is immediate to avoid a false fault
  always_ff @(posedge clk_i) begin
    cnt_q <= close_i ? ((cnt_q < DLY) ? cnt_q + 1 : cnt_q) : 0;
  end
  always_comb begin
    aux_o = mode_i == 2'h1 || (mode_i == 2'h0 && close_i && cnt_q == DLY);
  end
endmodule : dif_contactor_model
`default_nettype wire

// >>> dif_pkg.sv
/*
  Shared constants for the drive input and output function logic:
  register offsets, field positions, reset values, function codes and the
  timing counts. Assumes a 25 MHz system clock.
*/
package dif_pkg;
  // Clock and timer tick
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W = 22;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TMR = 8'h04;
  localparam logic [7:0] REG_FUNC = 8'h08;
  localparam logic [7:0] REG_SPEED = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_FUNC_HI = 8'h14;

  // CTRL fields
  localparam int CTRL_POLICY_LSB = 0;
  localparam int CTRL_ENC_PARAM = 2;
  localparam int CTRL_PM_MODE = 3;
  localparam int CTRL_FAULT_CLR = 4;
  localparam int CTRL_CLOSE_LSB = 8;
  localparam logic [1:0] POLICY_MANUAL = 2'h0;
  localparam logic [1:0] POLICY_AUTO = 2'h1;
  localparam logic [1:0] POLICY_OFF = 2'h2;
  localparam logic [1:0] POLICY_RST = POLICY_MANUAL;

  // TMR fields: delays in 0.1 s units, default 0.0 s
  localparam int TMR_ON_LSB = 0;
  localparam int TMR_OFF_LSB = 16;
  localparam logic [15:0] TMR_DLY_RST = 16'h0000;

  // FUNC fields: one byte per terminal, inputs a..e then outputs a..c
  localparam int N_IN = 5;
  localparam int N_OUT = 3;
  localparam logic [7:0] IN_FN_RST = 8'h00;
  localparam logic [7:0] OUT_FN_RST = 8'h00;

  // Function codes
  localparam logic [7:0] FN_IN_TIMER = 8'h18;
  localparam logic [7:0] FN_IN_CONT_FB = 8'h86;
  localparam logic [7:0] FN_IN_ENC_DIR = 8'h89;
  localparam logic [7:0] FN_IN_MOTOR2 = 8'h16;
  localparam logic [7:0] FN_OUT_TIMER = 8'h12;
  localparam logic [7:0] FN_OUT_MOTOR2 = 8'h1c;

  // Speed reference reset, 0.00 Hz in 0.01 Hz units
  localparam logic [15:0] SPEED2_RST = 16'h0000;

  // Contactor close delay, 0.1 s units
  localparam logic [7:0] CLOSE_DLY_RST = 8'h05;

  // STAT fields
  localparam int STAT_FAULT = 0;
  localparam int STAT_TIMER = 1;
  localparam int STAT_MOTOR2 = 2;
  localparam int STAT_ENC_CCW = 3;
endpackage : dif_pkg

// >>> dif_tb_top.sv
/*
  Testbench for the drive function logic over AHB-Lite.
  Assumes the 0.1 s tick never elapses within this short run.
*/
`timescale 1ns/1ns
`default_nettype none
module dif_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hrdy, hresp, fault, ccw, m2, aux;
  logic [3:0] term = 4'h0;
  logic [2:0] outs;
  logic run = 1'b0, close = 1'b0, svc = 1'b0, frst = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [15:0] sref = 16'h0abc;
  logic [15:0] sout;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  dif_top dut_u (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'b1),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .IN_TERM_I({term, aux}),
    .OUT_TERM_O(outs), .RUNNING_I(run), .CONTACTOR_CLOSE_I(close),
    .SERVICE_SPEED_I(svc), .SPEED_REF_I(sref), .FAULT_RESET_I(frst),
    .CONTACTOR_FAULT_O(fault), .ENC_DIR_CCW_O(ccw), .MOTOR2_SEL_O(m2),
    .SPEED_REF_O(sout));
  dif_contactor_model #(.DLY(8)) ctm_u (.clk_i(clk), .close_i(close),
    .mode_i(mode), .aux_o(aux));
  task automatic conclude();
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    chk("response", hresp, 1'b0);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("read data", hrdata, e);
  endtask : rd
  // Answer-back lost mid-run, then the stop decides whether it clears
  task automatic drop(input logic [1:0] pol, input logic ex);
    bus(1'b1, 8'h00, {30'h140, pol});
    close <= 1'b1;
    run <= 1'b1;
    w(4);
    chk("fault", fault, 1'b0);
    w(8);
    mode <= 2'h2;
    w(4);
    chk("fault", fault, pol != 2'h2);
    close <= 1'b0;
    w(2);
    mode <= 2'h0;
    run <= 1'b0;
    w(4);
    chk("fault", fault, ex);
  endtask : drop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    w(2);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0000_0500);
    rd(8'h04, 32'h0);
    rd(8'h0c, 32'h0);
    bus(1'b1, 8'h18, 32'hffff_ffff);
    rd(8'h18, 32'h0);
    bus(1'b1, 8'h08, 32'h1816_8986);
    bus(1'b1, 8'h14, 32'h001c_1200);
    bus(1'b1, 8'h04, 32'h0003_0002);
    run <= 1'b1;
    bus(1'b1, 8'h04, 32'h0009_0009);
    rd(8'h04, 32'h0003_0002);
    run <= 1'b0;
    term[2] <= 1'b1;
    w(1000);
    chk("timer out", outs[0], 1'b0);
    term[2] <= 1'b0;
    bus(1'b1, 8'h0c, 32'h0000_1234);
    for (int i = 0; i < 4; i++) begin
      term[1] <= i[0];
      svc <= i[1];
      w(3);
      chk("motor2", m2, i[0]);
      chk("motor2 out", outs[1], i[0]);
      chk("spare out", outs[2], 1'b0);
      chk("speed", sout, (i == 1) ? 32'h1234 : 32'h0abc);
    end
    svc <= 1'b0;
    bus(1'b1, 8'h00, 32'h0000_0508);
    w(2);
    chk("motor2", m2, 1'b0);
    bus(1'b1, 8'h00, 32'h0000_0504);
    for (int i = 0; i < 2; i++) begin
      term[0] <= i[0];
      w(2);
      chk("encoder dir", ccw, i[0]);
    end
    bus(1'b1, 8'h08, 32'h1816_0086);
    w(2);
    chk("encoder dir", ccw, 1'b1);
    bus(1'b1, 8'h00, 32'h0000_0500);
    mode <= 2'h1;
    w(4);
    chk("fault", fault, 1'b1);
    mode <= 2'h0;
    w(4);
    chk("fault", fault, 1'b1);
    frst <= 1'b1;
    w(2);
    frst <= 1'b0;
    w(2);
    chk("fault", fault, 1'b0);
    drop(2'h0, 1'b1);
    rd(8'h10, 32'h0000_0005);
    bus(1'b1, 8'h00, 32'h0000_0510);
    w(2);
    chk("fault", fault, 1'b0);
    drop(2'h1, 1'b0);
    drop(2'h2, 1'b0);
    mode <= 2'h1;
    w(4);
    chk("fault", fault, 1'b0);
    mode <= 2'h2;
    bus(1'b1, 8'h00, 32'h0000_0000);
    close <= 1'b1;
    w(4);
    chk("fault", fault, 1'b1);
    conclude();
  end
endmodule : dif_tb_top
`default_nettype wire

// >>> dif_timer.sv
/*
  On/off delay timer counted in 0.1 s ticks.
  Assumes tick is a one-cycle enable from the top's divider.
*/
`timescale 1ns/1ns
`default_nettype none
module dif_timer (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Timer link
  dif_timer_if.tmr tif
);
  logic out_q, out_d;
  logic prev_q, prev_d;
  logic [15:0] cnt_q, cnt_d;

  always_comb begin
    out_d = out_q;
    prev_d = tif.in_level;
    cnt_d = cnt_q;
    if (tif.in_level != prev_q) begin
      cnt_d = 16'h0000;
    end else if (tif.in_level != out_q) begin
      // Strictly longer than the delay: output moves past the last tick
      if (tif.in_level && cnt_q > tif.on_dly) begin
        out_d = 1'b1;
      end else if (!tif.in_level && cnt_q > tif.off_dly) begin
        out_d = 1'b0;
      end else if (tif.tick && cnt_q != 16'hffff) begin
        cnt_d = cnt_q + 16'h0001;
      end
    end else begin
      cnt_d = 16'h0000;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      out_q <= 1'b0;
      prev_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      out_q <= out_d;
      prev_q <= prev_d;
      cnt_q <= cnt_d;
    end
  end

  assign tif.out_level = out_q;
endmodule : dif_timer
`default_nettype wire

// >>> dif_timer_if.sv
/*
  Interface between the top and the on/off delay timer.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ns
`default_nettype none
interface dif_timer_if;
  logic tick;
  logic in_level;
  logic [15:0] on_dly;
  logic [15:0] off_dly;
  logic out_level;
  modport ctl (output tick, output in_level, output on_dly,
    output off_dly, input out_level);
  modport tmr (input tick, input in_level, input on_dly,
    input off_dly, output out_level);
endinterface : dif_timer_if
`default_nettype wire

// >>> dif_top.sv
/*
  Drive multifunction input/output logic: timer, contactor answer-back
  supervision, encoder direction input and second motor selection.
  Assumes synchronous terminal inputs, 25 MHz clock, AHB-Lite register bus.
*/
// Contract
// - Timer output sets after input on longer than the ON-delay.
// - Timer output clears after input off longer than the OFF-delay.
// - Both delays reset to zero; locked while the drive runs.
// - Input code 18 is timer input; output code 12 timer output.
// - Input code 86 is answer-back; missing answer raises contactor fault.
// - Policy 0 manual clear, 1 auto clear at stop, 2 no detection.
// - Fault if answer-back is on before the close command.
// - Fault if answer-back misses the close delay after close command.
// - Fault if answer-back drops while the drive runs.
// - Input code 89 sets encoder direction: open CW, closed CCW.
// - With code 89 assigned, the direction parameter is ignored.
// - Input code 16 selects motor 1 when off, motor 2 when on.
// - Output code 1C shows the selected motor set.
// - Motor 2 uses its own speed reference except in service speed.
// - Brake and contactor sequence is the same for both motors.
// - Motor 2 selection is unavailable in PM closed-loop vector.
// - With motor 2, brake sequence and rescue stay active.
// - Motor-select output off for motor 1, on for motor 2.
`timescale 1ns/1ns
`default_nettype none
module dif_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [7:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Terminals
  input wire logic [4:0] IN_TERM_I,
  output logic [2:0] OUT_TERM_O,
  // Drive state
  input wire logic RUNNING_I,
  input wire logic CONTACTOR_CLOSE_I,
  input wire logic SERVICE_SPEED_I,
  input wire logic [15:0] SPEED_REF_I,
  input wire logic FAULT_RESET_I,
  // Results
  output logic CONTACTOR_FAULT_O,
  output logic ENC_DIR_CCW_O,
  output logic MOTOR2_SEL_O,
  output logic [15:0] SPEED_REF_O
);
  // Bus registers
  logic [1:0] policy_q, policy_d;
  logic enc_param_q, enc_param_d;
  logic pm_mode_q, pm_mode_d;
  logic [15:0] on_dly_q, on_dly_d, off_dly_q, off_dly_d;
  logic [63:0] func_q, func_d;
  logic [15:0] speed2_q, speed2_d;
  logic [7:0] close_dly_q, close_dly_d;
  logic wr_ph_q, wr_ph_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic clr_req;
  // Divider
  logic [21:0] div_q, div_d;
  logic tick;
  // Contactor supervision
  typedef enum logic [2:0] {
    DIF_IDLE = 3'b001,
    DIF_WAIT = 3'b010,
    DIF_CLOSED = 3'b100
  } dif_cst_t;
  dif_cst_t cst_q, cst_d;
  logic [7:0] wait_q, wait_d;
  logic fault_q, fault_d;
  logic run_q, run_d;
  logic [15:0] spd_q, spd_d;

  // Whether any input terminal has a given function, and its level
  function automatic logic in_has(input logic [63:0] f,
                                  input logic [7:0] code);
    in_has = 1'b0;
    for (int i = 0; i < dif_pkg::N_IN; i++) begin
      if (f[i*8 +: 8] == code) in_has = 1'b1;
    end
  endfunction : in_has

  function automatic logic in_lvl(input logic [63:0] f,
                                  input logic [4:0] pins,
                                  input logic [7:0] code);
    in_lvl = 1'b0;
    for (int i = 0; i < dif_pkg::N_IN; i++) begin
      if (f[i*8 +: 8] == code && pins[i]) in_lvl = 1'b1;
    end
  endfunction : in_lvl

  logic tmr_in, fb_on, fb_used, enc_used, enc_lvl, m2_lvl, m2_sel, tmr_out;
  always_comb begin
    tmr_in = in_lvl(func_q, IN_TERM_I, dif_pkg::FN_IN_TIMER);
    fb_used = in_has(func_q, dif_pkg::FN_IN_CONT_FB);
    fb_on = in_lvl(func_q, IN_TERM_I, dif_pkg::FN_IN_CONT_FB);
    enc_used = in_has(func_q, dif_pkg::FN_IN_ENC_DIR);
    enc_lvl = in_lvl(func_q, IN_TERM_I, dif_pkg::FN_IN_ENC_DIR);
    m2_lvl = in_lvl(func_q, IN_TERM_I, dif_pkg::FN_IN_MOTOR2);
    m2_sel = m2_lvl && !pm_mode_q;
  end

  // Timer
  dif_timer_if tif ();
  assign tif.tick = tick;
  assign tif.in_level = tmr_in;
  assign tif.on_dly = on_dly_q;
  assign tif.off_dly = off_dly_q;
  assign tmr_out = tif.out_level;

  dif_timer u_timer (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .tif(tif)
  );

  // 0.1 s tick divider; the count is a package constant, so short runs
  // never see a tick and the timer cannot move within them
  always_comb begin
    tick = (div_q == 22'(dif_pkg::TICK_CYC - 1));
    div_d = tick ? 22'h000000 : div_q + 22'h000001;
  end

  // Bus: zero wait states, writes land in the data phase
  always_comb begin
    policy_d = policy_q;
    enc_param_d = enc_param_q;
    pm_mode_d = pm_mode_q;
    on_dly_d = on_dly_q;
    off_dly_d = off_dly_q;
    func_d = func_q;
    speed2_d = speed2_q;
    close_dly_d = close_dly_q;
    clr_req = 1'b0;
    addr_d = addr_q;
    wr_ph_d = 1'b0;
    rdata_d = rdata_q;
    if (HSEL_I && HREADY_I && HTRANS_I[1]) begin
      addr_d = HADDR_I;
      wr_ph_d = HWRITE_I;
      unique case (HADDR_I)
        dif_pkg::REG_CTRL: begin
          // Fault clear bit is write-only and reads back as zero
          rdata_d = 32'h00000000;
          rdata_d[dif_pkg::CTRL_POLICY_LSB +: 2] = policy_q;
          rdata_d[dif_pkg::CTRL_ENC_PARAM] = enc_param_q;
          rdata_d[dif_pkg::CTRL_PM_MODE] = pm_mode_q;
          rdata_d[dif_pkg::CTRL_CLOSE_LSB +: 8] = close_dly_q;
        end
        dif_pkg::REG_TMR: rdata_d = {off_dly_q, on_dly_q};
        dif_pkg::REG_FUNC: rdata_d = func_q[31:0];
        dif_pkg::REG_FUNC_HI: rdata_d = func_q[63:32];
        dif_pkg::REG_SPEED: rdata_d = {16'h0000, speed2_q};
        dif_pkg::REG_STAT: rdata_d = {28'h0000000, ENC_DIR_CCW_O,
          m2_sel, tmr_out, fault_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (wr_ph_q) begin
      unique case (addr_q)
        dif_pkg::REG_CTRL: begin
          // Settings hold while running; fault clear taken even while running, acted on under policy 0 only
          if (!RUNNING_I) begin
            policy_d = HWDATA_I[dif_pkg::CTRL_POLICY_LSB +: 2];
            enc_param_d = HWDATA_I[dif_pkg::CTRL_ENC_PARAM];
            pm_mode_d = HWDATA_I[dif_pkg::CTRL_PM_MODE];
            close_dly_d = HWDATA_I[dif_pkg::CTRL_CLOSE_LSB +: 8];
          end
          clr_req = HWDATA_I[dif_pkg::CTRL_FAULT_CLR];
        end
        dif_pkg::REG_TMR: begin
          if (!RUNNING_I) begin
            on_dly_d = HWDATA_I[dif_pkg::TMR_ON_LSB +: 16];
            off_dly_d = HWDATA_I[dif_pkg::TMR_OFF_LSB +: 16];
          end
        end
        dif_pkg::REG_FUNC: if (!RUNNING_I) func_d[31:0] = HWDATA_I;
        dif_pkg::REG_FUNC_HI: if (!RUNNING_I) func_d[63:32] = HWDATA_I;
        dif_pkg::REG_SPEED: if (!RUNNING_I) speed2_d = HWDATA_I[15:0];
        default: begin
        end
      endcase
    end
  end

  // Contactor answer-back supervision; same sequence for both motors
  always_comb begin
    cst_d = cst_q;
    wait_d = wait_q;
    fault_d = fault_q;
    run_d = RUNNING_I;
    // Clears first, so a fault raised below in the same cycle wins
    if (policy_q == dif_pkg::POLICY_MANUAL && (clr_req || FAULT_RESET_I))
      fault_d = 1'b0;
    if (policy_q == dif_pkg::POLICY_AUTO && run_q && !RUNNING_I)
      fault_d = 1'b0;
    unique case (cst_q)
      DIF_IDLE: begin
        wait_d = 8'h00;
        if (CONTACTOR_CLOSE_I) cst_d = DIF_WAIT;
      end
      DIF_WAIT: begin
        if (!CONTACTOR_CLOSE_I) cst_d = DIF_IDLE;
        else if (fb_on) cst_d = DIF_CLOSED;
        else if (wait_q >= close_dly_q) begin
          fault_d = 1'b1;
          cst_d = DIF_IDLE;
        end else if (tick) wait_d = wait_q + 8'h01;
      end
      DIF_CLOSED: begin
        if (!CONTACTOR_CLOSE_I) cst_d = DIF_IDLE;
        else if (!fb_on && RUNNING_I) fault_d = 1'b1;
      end
      default: cst_d = DIF_IDLE;
    endcase
    // Welded contact: answer-back already on before the close command
    if (cst_q == DIF_IDLE && !CONTACTOR_CLOSE_I && fb_on) begin
      fault_d = 1'b1;
    end
    if (policy_q == dif_pkg::POLICY_OFF || !fb_used) begin
      fault_d = 1'b0;
      cst_d = DIF_IDLE;
    end
  end

  // Speed reference select
  always_comb begin
    spd_d = (m2_sel && !SERVICE_SPEED_I) ? speed2_q : SPEED_REF_I;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      policy_q <= dif_pkg::POLICY_RST;
      enc_param_q <= 1'b0;
      pm_mode_q <= 1'b0;
      on_dly_q <= dif_pkg::TMR_DLY_RST;
      off_dly_q <= dif_pkg::TMR_DLY_RST;
      func_q <= 64'h0000000000000000;
      speed2_q <= dif_pkg::SPEED2_RST;
      close_dly_q <= dif_pkg::CLOSE_DLY_RST;
      wr_ph_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
      div_q <= 22'h000000;
      cst_q <= DIF_IDLE;
      wait_q <= 8'h00;
      fault_q <= 1'b0;
      run_q <= 1'b0;
      spd_q <= 16'h0000;
    end else begin
      policy_q <= policy_d;
      enc_param_q <= enc_param_d;
      pm_mode_q <= pm_mode_d;
      on_dly_q <= on_dly_d;
      off_dly_q <= off_dly_d;
      func_q <= func_d;
      speed2_q <= speed2_d;
      close_dly_q <= close_dly_d;
      wr_ph_q <= wr_ph_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      div_q <= div_d;
      cst_q <= cst_d;
      wait_q <= wait_d;
      fault_q <= fault_d;
      run_q <= run_d;
      spd_q <= spd_d;
    end
  end

  // Outputs
  always_comb begin
    for (int j = 0; j < dif_pkg::N_OUT; j++) begin
      unique case (func_q[(dif_pkg::N_IN + j)*8 +: 8])
        dif_pkg::FN_OUT_TIMER: OUT_TERM_O[j] = tmr_out;
        dif_pkg::FN_OUT_MOTOR2: OUT_TERM_O[j] = m2_sel;
        default: OUT_TERM_O[j] = 1'b0;
      endcase
    end
  end

  // Input level wins over the parameter whenever the input is assigned
  assign ENC_DIR_CCW_O = enc_used ? enc_lvl : enc_param_q;
  assign MOTOR2_SEL_O = m2_sel;
  assign CONTACTOR_FAULT_O = fault_q;
  assign SPEED_REF_O = spd_q;
  assign HRDATA_O = rdata_q;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
endmodule : dif_top
`default_nettype wire

// >>> dif_top_properties.sv
/*
  Port checker for the drive function logic.
  Assumes word-only zero-wait AHB writes and that bus writes are the only
  way the function and control registers change.
*/
`timescale 1ns/1ns
`default_nettype none
module dif_top_properties (
  // Clock, reset and bus
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [7:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  // Terminals and drive state
  input wire logic [4:0] IN_TERM_I,
  input wire logic [2:0] OUT_TERM_O,
  input wire logic RUNNING_I,
  input wire logic CONTACTOR_CLOSE_I,
  input wire logic SERVICE_SPEED_I,
  input wire logic [15:0] SPEED_REF_I,
  input wire logic FAULT_RESET_I,
  input wire logic CONTACTOR_FAULT_O,
  input wire logic ENC_DIR_CCW_O,
  input wire logic MOTOR2_SEL_O,
  input wire logic [15:0] SPEED_REF_O
);
  logic aw_q;
  logic [7:0] aa_q;
  logic [31:0] ctl_q, flo_q, fhi_q;
  logic [39:0] fn;
  logic fb_on, fbv, enc_on, encv, m2v, clr;
  logic [2:0] o1c;
  logic [1:0] pol;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Shadow of the writable setup, so codes can be decoded here
  always_ff @(posedge CLK_I) begin
    aw_q <= RST_N_I && HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
    aa_q <= HADDR_I;
    if (!RST_N_I) begin
      ctl_q <= 32'h0;
      flo_q <= 32'h0;
      fhi_q <= 32'h0;
    end else if (aw_q && !RUNNING_I) begin
      if (aa_q == dif_pkg::REG_CTRL) ctl_q <= HWDATA_I;
      if (aa_q == dif_pkg::REG_FUNC) flo_q <= HWDATA_I;
      if (aa_q == dif_pkg::REG_FUNC_HI) fhi_q <= HWDATA_I;
    end
  end
  always_comb begin
    fn = {fhi_q[7:0], flo_q};
    pol = ctl_q[1:0];
    clr = aw_q && aa_q == dif_pkg::REG_CTRL && HWDATA_I[4];
    {fb_on, fbv, enc_on, encv, m2v} = 5'h0;
    for (int i = 0; i < 5; i++) begin
      if (fn[8*i+:8] == dif_pkg::FN_IN_CONT_FB) begin
        fb_on = 1'b1;
        fbv |= IN_TERM_I[i];
      end
      if (fn[8*i+:8] == dif_pkg::FN_IN_ENC_DIR) begin
        enc_on = 1'b1;
        encv |= IN_TERM_I[i];
      end
      if (fn[8*i+:8] == dif_pkg::FN_IN_MOTOR2) m2v |= IN_TERM_I[i];
    end
    for (int j = 0; j < 3; j++) o1c[j] = fhi_q[8*j+8+:8] == 8'h1c;
  end
  property p_m2; MOTOR2_SEL_O == (m2v && !ctl_q[3]); endproperty
  a_m2: assert property (p_m2) else $error("motor select");
  property p_m2o; (o1c & (OUT_TERM_O ^ {3{MOTOR2_SEL_O}})) == 3'h0; endproperty
  a_m2o: assert property (p_m2o) else $error("motor out");
  property p_enc; ENC_DIR_CCW_O == (enc_on ? encv : ctl_q[2]); endproperty
  a_enc: assert property (p_enc) else $error("encoder dir");
  property p_spd;
    $past(RST_N_I && (!MOTOR2_SEL_O || SERVICE_SPEED_I))
      |-> SPEED_REF_O == $past(SPEED_REF_I);
  endproperty
  a_spd: assert property (p_spd) else $error("speed ref");
  property p_early;
    pol != 2'h2 && fb_on && fbv && !CONTACTOR_CLOSE_I
      |-> ##[1:2] CONTACTOR_FAULT_O;
  endproperty
  a_early: assert property (p_early) else $error("early fb");
  property p_drop;
    pol != 2'h2 && fb_on && $fell(fbv) && CONTACTOR_CLOSE_I && RUNNING_I
      |-> ##[1:2] CONTACTOR_FAULT_O;
  endproperty
  a_drop: assert property (p_drop) else $error("fb drop");
  property p_off; (pol == 2'h2)[*3] |-> !CONTACTOR_FAULT_O; endproperty
  a_off: assert property (p_off) else $error("fault off");
  property p_hold;
    pol == 2'h0 && fb_on && CONTACTOR_FAULT_O && !FAULT_RESET_I
      && !$past(FAULT_RESET_I) && !clr && !$past(clr) |=> CONTACTOR_FAULT_O;
  endproperty
  a_hold: assert property (p_hold) else $error("fault hold");
  property p_auto;
    pol == 2'h1 && $fell(RUNNING_I) && !fbv && !CONTACTOR_CLOSE_I
      |-> ##[1:2] !CONTACTOR_FAULT_O;
  endproperty
  a_auto: assert property (p_auto) else $error("auto clear");
endmodule : dif_top_properties
bind dif_top dif_top_properties chk_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
  .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
  .IN_TERM_I(IN_TERM_I), .OUT_TERM_O(OUT_TERM_O), .RUNNING_I(RUNNING_I),
  .CONTACTOR_CLOSE_I(CONTACTOR_CLOSE_I), .SERVICE_SPEED_I(SERVICE_SPEED_I),
  .SPEED_REF_I(SPEED_REF_I), .FAULT_RESET_I(FAULT_RESET_I),
  .CONTACTOR_FAULT_O(CONTACTOR_FAULT_O), .ENC_DIR_CCW_O(ENC_DIR_CCW_O),
  .MOTOR2_SEL_O(MOTOR2_SEL_O), .SPEED_REF_O(SPEED_REF_O));
`default_nettype wire
